// >>> wake_cfg_pkg.sv
// constants and types for the wake source configuration register bank
package wake_cfg_pkg;
   // register addresses on the serial control frame (7-bit)
   localparam logic [6:0] ADDR_PEAK = 7'h05;
   localparam logic [6:0] ADDR_INT_WAKE = 7'h06;
   localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;
   localparam logic [6:0] ADDR_PULL = 7'h08;

   // field positions
   localparam int PEAK_SEL_BIT = 5;
   localparam int T2_WAKE_BIT = 7;
   localparam int T1_WAKE_BIT = 6;
   localparam int WD_OFF_HI_BIT = 2;
   localparam int SCOPE_BIT = 7;
   localparam int MEAS_BIT = 5;
   localparam int WAKE_INPUT_THREE_ENABLE_BIT = 2;
   localparam int WAKE_INPUT_TWO_ENABLE_BIT = 1;
   localparam int WAKE_INPUT_ONE_ENABLE_BIT = 0;
   localparam int PULL_W = 2;

   // power-on / soft reset values
   localparam logic [7:0] PEAK_RST = 8'h00;
   localparam logic [7:0] INT_WAKE_RST = 8'h00;
   localparam logic [7:0] EXT_WAKE_RST = 8'h07;
   localparam logic [7:0] PULL_RST = 8'h00;

   // host-writable bits; everything else is reserved and reads zero
   localparam logic [7:0] PEAK_WMASK = 8'h20;
   localparam logic [7:0] INT_WAKE_WMASK = 8'hc4;
   localparam logic [7:0] EXT_WAKE_WMASK = 8'ha7;
   localparam logic [7:0] PULL_WMASK = 8'h3f;

   // bits kept on restart entry, the rest clear
   localparam logic [7:0] PEAK_KEEP = 8'h20;
   localparam logic [7:0] INT_WAKE_KEEP = 8'hc0;
   localparam logic [7:0] EXT_WAKE_KEEP = 8'ha7;
   localparam logic [7:0] PULL_KEEP = 8'h3f;

   // fail-safe patterns
   localparam logic [7:0] PEAK_FS = 8'h01;
   localparam logic [7:0] EXT_FS_KEEP = 8'ha0;
   localparam logic [7:0] EXT_FS_SET = 8'h07;
   localparam logic [2:0] BUS_MODE_FS = 3'h1;

   // pull field encodings
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_DOWN = 2'h1;
   localparam logic [1:0] PULL_UP = 2'h2;
   localparam logic [1:0] PULL_AUTO = 2'h3;

   typedef enum logic [2:0] {
      MODE_INIT,
      MODE_NORMAL,
      MODE_STOP,
      MODE_SLEEP,
      MODE_RESTART,
      MODE_FAILSAFE
   } op_mode_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [7:0] peak;
      logic [7:0] int_wake;
      logic [7:0] ext_wake;
      logic [7:0] pull;
      logic [7:0] rdata;
      logic rvalid;
      logic irq;
      logic bus_fs_load;
   } bank_state_t;
endpackage

// >>> wake_source_control_regs.sv
// wake source configuration register bank with its mode-dependent updates
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
module wake_source_control_regs
   import wake_cfg_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire reg_req_t req_i,
   input wire op_mode_t mode_i,
   input wire logic soft_reset_i,
   input wire logic restart_entry_i,
   input wire logic failsafe_entry_i,
   input wire logic wd_off_set_i,
   input wire logic wd_off_clr_i,
   input wire logic wake_event_i,
   input wire logic status_event_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic access_fail_o,
   output logic irq_o,
   output logic bus_fs_load_o,
   output logic [2:0] bus_fs_mode_o,
   output logic peak_high_o,
   output logic timer2_wake_en_o,
   output logic timer1_wake_en_o,
   output logic stop_watchdog_off_bit_hi_o,
   output logic [2:0] wake_input_en_o,
   output logic meas_active_o,
   output logic [2:0] pull_up_o,
   output logic [2:0] pull_down_o,
   output logic [2:0] pull_auto_o
);

   bank_state_t cur;
   bank_state_t next_cur;
   logic hit;
   logic peak_unlocked;

   //////////////////////////////////////////////////////////////////////////
   // address decode and write permission
   always_comb begin
      hit = (req_i.addr == ADDR_PEAK) || (req_i.addr == ADDR_INT_WAKE) ||
            (req_i.addr == ADDR_EXT_WAKE) || (req_i.addr == ADDR_PULL);
      peak_unlocked = (mode_i == MODE_INIT) || (mode_i == MODE_NORMAL);
   end

   // stop-mode peak writes are silently dropped, only unmapped addresses fail
   assign access_fail_o = (req_i.wr || req_i.rd) && !hit;

   //////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_cur = cur;
      next_cur.rvalid = 1'b0;
      next_cur.bus_fs_load = 1'b0;
      if (failsafe_entry_i) begin
         // fail-safe outranks a simultaneous host write so wake stays possible
         next_cur.peak = PEAK_FS & PEAK_WMASK;
         next_cur.ext_wake = (cur.ext_wake & EXT_FS_KEEP) | EXT_FS_SET;
         next_cur.bus_fs_load = 1'b1;
      end else if (restart_entry_i) begin
         next_cur.peak = cur.peak & PEAK_KEEP;
         next_cur.int_wake = cur.int_wake & INT_WAKE_KEEP;
         next_cur.ext_wake = cur.ext_wake & EXT_WAKE_KEEP;
         next_cur.pull = cur.pull & PULL_KEEP;
      end else if (soft_reset_i) begin
         next_cur.peak = PEAK_RST;
         next_cur.int_wake = INT_WAKE_RST;
         next_cur.ext_wake = EXT_WAKE_RST;
         next_cur.pull = PULL_RST;
      end else if (req_i.wr) begin
         unique case (req_i.addr)
            ADDR_PEAK: begin
               if (peak_unlocked) begin
                  next_cur.peak = req_i.wdata & PEAK_WMASK;
               end
            end
            ADDR_INT_WAKE: begin
               next_cur.int_wake = req_i.wdata & INT_WAKE_WMASK;
            end
            ADDR_EXT_WAKE: begin
               next_cur.ext_wake = req_i.wdata & EXT_WAKE_WMASK;
            end
            ADDR_PULL: begin
               next_cur.pull = req_i.wdata & PULL_WMASK;
            end
            default: begin
               next_cur.peak = cur.peak;
            end
         endcase
      end
      // the device's own watchdog update beats a host write in the same cycle
      if (!failsafe_entry_i && !restart_entry_i && !soft_reset_i) begin
         if (wd_off_set_i) begin
            next_cur.int_wake[WD_OFF_HI_BIT] = 1'b1;
         end else if (wd_off_clr_i) begin
            next_cur.int_wake[WD_OFF_HI_BIT] = 1'b0;
         end
      end
      if (req_i.rd) begin
         next_cur.rvalid = 1'b1;
         unique case (req_i.addr)
            ADDR_PEAK: next_cur.rdata = cur.peak & PEAK_WMASK;
            ADDR_INT_WAKE: next_cur.rdata = cur.int_wake & INT_WAKE_WMASK;
            ADDR_EXT_WAKE: next_cur.rdata = cur.ext_wake & EXT_WAKE_WMASK;
            ADDR_PULL: next_cur.rdata = cur.pull & PULL_WMASK;
            default: next_cur.rdata = 8'h00;
         endcase
      end
      // scope bit: wake events always, other status only when widened
      next_cur.irq = wake_event_i ||
                     (cur.ext_wake[SCOPE_BIT] && status_event_i);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cur <= '{peak: PEAK_RST, int_wake: INT_WAKE_RST,
                  ext_wake: EXT_WAKE_RST, pull: PULL_RST, rdata: 8'h00,
                  rvalid: 1'b0, irq: 1'b0, bus_fs_load: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs
   assign rdata_o = cur.rdata;
   assign rvalid_o = cur.rvalid;
   assign irq_o = cur.irq;
   assign bus_fs_load_o = cur.bus_fs_load;
   assign bus_fs_mode_o = BUS_MODE_FS;
   assign peak_high_o = cur.peak[PEAK_SEL_BIT];
   assign timer2_wake_en_o = cur.int_wake[T2_WAKE_BIT];
   assign timer1_wake_en_o = cur.int_wake[T1_WAKE_BIT];
   assign stop_watchdog_off_bit_hi_o = cur.int_wake[WD_OFF_HI_BIT];
   assign wake_input_en_o[2] = cur.ext_wake[WAKE_INPUT_THREE_ENABLE_BIT];
   // measurement mode takes inputs one and two away from wake duty
   assign wake_input_en_o[1] = cur.ext_wake[WAKE_INPUT_TWO_ENABLE_BIT] &&
                               !cur.ext_wake[MEAS_BIT];
   assign wake_input_en_o[0] = cur.ext_wake[WAKE_INPUT_ONE_ENABLE_BIT] &&
                               !cur.ext_wake[MEAS_BIT];
   assign meas_active_o = cur.ext_wake[MEAS_BIT] &&
                          (mode_i == MODE_NORMAL);

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pull
         logic [1:0] fld;
         assign fld = cur.pull[gi*PULL_W +: PULL_W];
         assign pull_up_o[gi] = (fld == PULL_UP);
         assign pull_down_o[gi] = (fld == PULL_DOWN);
         assign pull_auto_o[gi] = (fld == PULL_AUTO);
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   logic plain_write;
   assign plain_write = req_i.wr && !failsafe_entry_i && !restart_entry_i &&
                        !soft_reset_i;

   a_peak_stop_lock: assert property (
      plain_write && req_i.addr == ADDR_PEAK && mode_i == MODE_STOP
      |=> $stable(peak_high_o))
      else $error("peak select changed by a stop-mode write");
   a_peak_write_ok: assert property (
      plain_write && req_i.addr == ADDR_PEAK && mode_i == MODE_NORMAL
      |=> peak_high_o == $past(req_i.wdata[PEAK_SEL_BIT]))
      else $error("peak select did not take the written value");
   a_stop_no_fail: assert property (
      req_i.wr && req_i.addr == ADDR_PEAK |-> !access_fail_o)
      else $error("access fail raised on a peak write");
   a_fs_wake_load: assert property (
      failsafe_entry_i |=> wake_input_en_o[2] && bus_fs_load_o &&
      !peak_high_o ##1 !bus_fs_load_o)
      else $error("fail-safe patterns not loaded");
   a_restart_timers: assert property (
      restart_entry_i && !failsafe_entry_i |=>
      timer2_wake_en_o == $past(timer2_wake_en_o) &&
      timer1_wake_en_o == $past(timer1_wake_en_o) &&
      !stop_watchdog_off_bit_hi_o)
      else $error("restart did not keep only the timer enables");
   a_restart_peak: assert property (
      restart_entry_i && !failsafe_entry_i |=> $stable(peak_high_o))
      else $error("restart lost the peak select");
   a_soft_reset_ext: assert property (
      soft_reset_i && !failsafe_entry_i && !restart_entry_i |=>
      wake_input_en_o == 3'h7 && !meas_active_o)
      else $error("soft reset did not enable all wake inputs");
   a_meas_masks_wk: assert property (
      cur.ext_wake[MEAS_BIT] |-> wake_input_en_o[1:0] == 2'h0)
      else $error("wake inputs one/two active during measurement");
   a_irq_scope: assert property (
      status_event_i && !wake_event_i && !cur.ext_wake[SCOPE_BIT]
      |=> !irq_o)
      else $error("interrupt raised outside wake scope");
   a_reserved_zero: assert property (
      req_i.rd && req_i.addr == ADDR_PEAK
      |=> rvalid_o && (rdata_o & ~PEAK_WMASK) == 8'h00)
      else $error("reserved peak register bit read as one");
   a_int_reserved_zero: assert property (
      req_i.rd && req_i.addr == ADDR_INT_WAKE
      |=> rvalid_o && (rdata_o & ~INT_WAKE_WMASK) == 8'h00)
      else $error("reserved internal wake bit read as one");
   a_ext_reserved_zero: assert property (
      req_i.rd && req_i.addr == ADDR_EXT_WAKE
      |=> rvalid_o && (rdata_o & ~EXT_WAKE_WMASK) == 8'h00)
      else $error("reserved external wake bit read as one");
   a_pull_reserved_zero: assert property (
      req_i.rd && req_i.addr == ADDR_PULL
      |=> rvalid_o && (rdata_o & ~PULL_WMASK) == 8'h00)
      else $error("reserved pull register bit read as one");
   a_wd_device_set: assert property (
      wd_off_set_i && !failsafe_entry_i && !restart_entry_i &&
      !soft_reset_i |=> stop_watchdog_off_bit_hi_o)
      else $error("device set of watchdog-off bit lost");
   a_wd_device_clr: assert property (
      wd_off_clr_i && !wd_off_set_i && !failsafe_entry_i &&
      !restart_entry_i && !soft_reset_i |=> !stop_watchdog_off_bit_hi_o)
      else $error("device clear of watchdog-off bit lost");
   a_read_one_cycle: assert property (
      !req_i.rd |=> !rvalid_o)
      else $error("read valid without a read request");
   a_unmapped_read: assert property (
      req_i.rd && (req_i.addr < ADDR_PEAK || req_i.addr > ADDR_PULL)
      |-> access_fail_o ##1 rdata_o == 8'h00)
      else $error("unmapped read not failed or not zero");
   // a locked peak write stays silent whatever the scope bit says
   a_stop_no_irq: assert property (
      plain_write && req_i.addr == ADDR_PEAK && mode_i == MODE_STOP &&
      !wake_event_i && !status_event_i |=> !irq_o)
      else $error("interrupt raised by a stop-mode peak write");
   a_wake_irq: assert property (
      wake_event_i |=> irq_o)
      else $error("wake event did not raise the interrupt");
   a_scope_all_irq: assert property (
      status_event_i && cur.ext_wake[SCOPE_BIT] |=> irq_o)
      else $error("widened scope did not raise the interrupt");
   a_timer2_write: assert property (
      plain_write && req_i.addr == ADDR_INT_WAKE
      |=> timer2_wake_en_o == $past(req_i.wdata[T2_WAKE_BIT]))
      else $error("second timer wake enable not written");
   a_timer1_write: assert property (
      plain_write && req_i.addr == ADDR_INT_WAKE
      |=> timer1_wake_en_o == $past(req_i.wdata[T1_WAKE_BIT]))
      else $error("first timer wake enable not written");
   a_ext_enable_write: assert property (
      plain_write && req_i.addr == ADDR_EXT_WAKE && !req_i.wdata[MEAS_BIT]
      |=> wake_input_en_o == $past(req_i.wdata[2:0]))
      else $error("wake input enables not written");
   a_meas_normal_only: assert property (
      mode_i != MODE_NORMAL |-> !meas_active_o)
      else $error("measurement active outside normal mode");
   a_meas_runs_normal: assert property (
      plain_write && req_i.addr == ADDR_EXT_WAKE && req_i.wdata[MEAS_BIT]
      ##1 mode_i == MODE_NORMAL |-> meas_active_o)
      else $error("measurement not running in normal mode");
   a_pull_down_code: assert property (
      plain_write && req_i.addr == ADDR_PULL &&
      req_i.wdata[1:0] == PULL_DOWN |=> pull_down_o[0] &&
      !pull_up_o[0] && !pull_auto_o[0])
      else $error("pull-down code not decoded");
   a_pull_up_code: assert property (
      plain_write && req_i.addr == ADDR_PULL &&
      req_i.wdata[3:2] == PULL_UP |=> pull_up_o[1] &&
      !pull_down_o[1] && !pull_auto_o[1])
      else $error("pull-up code not decoded");
   a_pull_auto_code: assert property (
      plain_write && req_i.addr == ADDR_PULL &&
      req_i.wdata[5:4] == PULL_AUTO |=> pull_auto_o[2] &&
      !pull_up_o[2] && !pull_down_o[2])
      else $error("automatic pull code not decoded");
   a_restart_ext_keep: assert property (
      restart_entry_i && !failsafe_entry_i |=> $stable(wake_input_en_o))
      else $error("restart changed the wake input enables");
   a_restart_pull_keep: assert property (
      restart_entry_i && !failsafe_entry_i |=> $stable(pull_up_o) &&
      $stable(pull_down_o) && $stable(pull_auto_o))
      else $error("restart changed the pull configuration");
   a_fs_timer_keep: assert property (
      failsafe_entry_i |=> $stable(timer2_wake_en_o) &&
      $stable(timer1_wake_en_o) && $stable(stop_watchdog_off_bit_hi_o))
      else $error("fail-safe disturbed the internal wake register");
   a_soft_reset_clear: assert property (
      soft_reset_i && !failsafe_entry_i && !restart_entry_i |=>
      !peak_high_o && !timer2_wake_en_o && !timer1_wake_en_o &&
      !stop_watchdog_off_bit_hi_o)
      else $error("soft reset did not clear peak and internal wake");
endmodule

// >>> wake_host_model.sv
// host side model that issues register frames to the wake bank
`timescale 1ns/10ps
module wake_host_model
   import wake_cfg_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i,
   input wire logic access_fail_i,
   output reg_req_t req_o
);
   initial req_o = '0;
   // wake level bits and the transceiver mode are never touched here
   task automatic acc(input logic w, input logic [6:0] a,
         input logic [7:0] d, output logic [7:0] q, output logic f,
         output logic ok);
      @(negedge clk_sys_i);
      req_o <= '{w, ~w, a, d};
      #1 f = access_fail_i;
      ok = w;
      q = 8'h00;
      @(negedge clk_sys_i);
      // released lines show the inverse so stale data cannot pass
      req_o <= '{1'b0, 1'b0, ~a, ~d};
      for (int i = 0; i < 3 && !ok; i++) begin
         if (rvalid_i === 1'b1) begin
            ok = 1'b1;
            q = rdata_i;
         end else begin
            @(negedge clk_sys_i);
         end
      end
   endtask
endmodule

// >>> wake_source_control_regs_tb_top.sv
// self-checking bench for the wake source configuration bank
`timescale 1ns/10ps
module wake_source_control_regs_tb_top;
   import wake_cfg_pkg::*;
   typedef struct packed {
      logic [6:0] a;
      logic [7:0] d, e, r, s;
   } row_t;
   row_t rows [4];
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   op_mode_t mode = MODE_NORMAL;
   logic [6:0] ev = '0;
   reg_req_t req;
   logic [7:0] rdata, q;
   logic rvalid, fail, irq, fs_load, peak, t2, t1, wd, meas, f, ok;
   logic [2:0] fs_mode, wen, pu, pd, pa;
   int num_errors = 0;
   int num_checks = 0;

   initial forever #2.5 clk_sys_i = ~clk_sys_i;

   wake_host_model i_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
      .rvalid_i(rvalid), .access_fail_i(fail), .req_o(req));

   wake_source_control_regs i_dut (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .req_i(req), .mode_i(mode),
      .soft_reset_i(ev[0]), .restart_entry_i(ev[1]),
      .failsafe_entry_i(ev[2]), .wd_off_set_i(ev[3]),
      .wd_off_clr_i(ev[4]), .wake_event_i(ev[5]),
      .status_event_i(ev[6]), .rdata_o(rdata), .rvalid_o(rvalid),
      .access_fail_o(fail), .irq_o(irq), .bus_fs_load_o(fs_load),
      .bus_fs_mode_o(fs_mode), .peak_high_o(peak),
      .timer2_wake_en_o(t2), .timer1_wake_en_o(t1),
      .stop_watchdog_off_bit_hi_o(wd), .wake_input_en_o(wen),
      .meas_active_o(meas), .pull_up_o(pu), .pull_down_o(pd),
      .pull_auto_o(pa));

   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // read and compare; a read that never answers ends the run
   task automatic rc(input logic [6:0] a, input logic [7:0] e);
      i_host.acc(1'b0, a, 8'h00, q, f, ok);
      if (!ok) begin
         num_errors++;
         complete_run();
      end else begin
         chk(q, e);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_host.acc(1'b1, a, d, q, f, ok);
   endtask

   task automatic pulse(input int k);
      @(negedge clk_sys_i);
      ev <= 7'(1 << k);
      @(negedge clk_sys_i);
      ev <= '0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      // address, write data, read-back, reset value, after restart
      rows[0] = '{7'h05, 8'hff, 8'h20, 8'h00, 8'h20};
      rows[1] = '{7'h06, 8'hff, 8'hc4, 8'h00, 8'hc0};
      rows[2] = '{7'h07, 8'hff, 8'ha7, 8'h07, 8'ha7};
      rows[3] = '{7'h08, 8'hff, 8'h3f, 8'h00, 8'h3f};
      repeat (16) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      foreach (rows[i]) rc(rows[i].a, rows[i].r);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rc(rows[i].a, rows[i].e);
      end
      chk({peak, t2, t1, wd, 1'b0, wen}, 8'hf4);
      chk({7'h00, meas}, 8'h01);
      chk({5'h00, pa}, 8'h07);
      mode = MODE_STOP;
      wr(7'h05, 8'h00);
      chk({6'h00, f, irq}, 8'h00);
      rc(7'h05, 8'h20);
      chk({7'h00, meas}, 8'h00);
      pulse(6);
      chk({7'h00, irq}, 8'h01);
      mode = MODE_INIT;
      wr(7'h05, 8'h00);
      rc(7'h05, 8'h00);
      chk({7'h00, meas}, 8'h00);
      mode = MODE_NORMAL;
      wr(7'h07, 8'h07);
      chk({5'h00, wen}, 8'h07);
      pulse(6);
      chk({7'h00, irq}, 8'h00);
      pulse(5);
      chk({7'h00, irq}, 8'h01);
      wr(7'h08, 8'h39);
      chk({2'b00, pa, pu}, 8'h22);
      chk({5'h00, pd}, 8'h01);
      pulse(4);
      rc(7'h06, 8'hc0);
      pulse(3);
      rc(7'h06, 8'hc4);
      i_host.acc(1'b0, 7'h09, 8'h00, q, f, ok);
      chk({f, q[6:0]}, 8'h80);
      chk({7'h00, ok}, 8'h01);
      foreach (rows[i]) wr(rows[i].a, rows[i].d);
      pulse(1);
      foreach (rows[i]) rc(rows[i].a, rows[i].s);
      wr(7'h07, 8'h80);
      pulse(2);
      chk({4'h0, fs_load, fs_mode}, 8'h09);
      rc(7'h05, 8'h00);
      rc(7'h07, 8'h87);
      pulse(0);
      foreach (rows[i]) rc(rows[i].a, rows[i].r);
      // asynchronous reset in mid-run must restore the same values
      foreach (rows[i]) wr(rows[i].a, rows[i].d);
      @(negedge clk_sys_i);
      rst_n_i = 1'b0;
      #1 chk({peak, t2, t1, wd, irq, wen}, 8'h07);
      @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      foreach (rows[i]) rc(rows[i].a, rows[i].r);
      complete_run();
   end
endmodule
